// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import vodc_pkg::*;
  localparam logic [7:0] OFS_LIST [8] = '{OFS_OUTPUT_CFG, OFS_HWINDOW, OFS_VWINDOW, OFS_SCALE, OFS_KEY,
    OFS_MASK, OFS_MISC, OFS_PLL};
  localparam logic [31:0] WMASK [8] = '{OUTPUT_CFG_WMASK, HWIN_WMASK, VWIN_WMASK, SCALE_WMASK, KEY_WMASK,
    KEY_WMASK, MISC_WMASK, PLL_WMASK};
  logic clock = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, seed = 32'hbb9c8a28;
  logic regRvalid, lineSyncIn, frameSyncIn, lineBlankIn, frameBlankIn, crtHsync, dacBlank;
  logic panelPowerOn, monitorLogicResetN, keyIsYuv, secondPllTick;
  logic [11:0] pixelX;
  logic [10:0] lineY;
  vodc_pixel_t gfxPixel, vidPixel, crtPixel;
  int syncEdges, failures = 0, n_checks = 0;
  vodc_top dut_u (.clock, .resetn, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .regRvalid,
    .lineSyncIn, .frameSyncIn, .lineBlankIn, .frameBlankIn, .pixelX, .lineY, .gfxPixel, .vidPixel,
    .crtHsync, .crtVsync(), .dacBlank, .crtPixel, .panelPixel(), .panelPowerOn, .monitorLogicResetN,
    .keyIsYuv, .horizontalScaleStep(), .verticalScaleStep(), .secondPllRun(), .bandgapRun(),
    .converterSleep(), .secondPllTick);
  vodc_display_model disp_u (.clock, .resetn, .crtHsync, .lineSyncIn, .frameSyncIn, .lineBlankIn,
    .frameBlankIn, .pixelX, .lineY, .syncEdges);
  always #2.5 clock = ~clock;
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [23:0] gam(input logic [7:0] j);
    return {~j, j ^ 8'h5a, j + 8'h11};
  endfunction : gam
  function automatic vodc_pixel_t gmap(input vodc_pixel_t p);
    return {~p.blue, p.green ^ 8'h5a, p.red + 8'h11};
  endfunction : gmap
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clock);
    regWr = 1'b0;
  endtask : wr
  // Answer lands on the edge that takes the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(negedge clock);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clock);
    regRd = 1'b0;
    chk({31'h0, regRvalid}, 32'h1);
    chk(regRdata, e);
  endtask : rdc
  // Input held steady so the two-stage path has settled
  task automatic pix(input vodc_pixel_t g, input vodc_pixel_t v, input vodc_pixel_t e);
    @(negedge clock);
    gfxPixel = g;
    vidPixel = v;
    repeat (3) @(negedge clock);
    if (dacBlank === 1'b0) chk({8'h0, crtPixel}, {8'h0, e});
  endtask : pix
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  // ==========================================
  // Tests
  initial begin
    vodc_pixel_t g, v, e, src, fix;
    logic [31:0] key, msk;
    logic hit;
    int n;
    regAddr = 8'h0;
    regWdata = 32'h0;
    gfxPixel = '0;
    vidPixel = '0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    foreach (OFS_LIST[i]) rdc(OFS_LIST[i], OFS_LIST[i] == OFS_MISC ? RST_MISC : RST_ZERO);
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 8; i++) begin
        key = rnd() & 32'hffff_ffbf;
        wr(OFS_LIST[i], key);
        rdc(OFS_LIST[i], key & WMASK[i]);
        repeat (8) @(negedge clock);
      end
    end
    wr(8'h30, rnd());
    rdc(8'h30, RST_ZERO);
    wr(OFS_SCALE, 32'h1000_2000);
    rdc(OFS_SCALE, 32'h1000_2000);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_FORMAT, {18'h0, i[1], 2'b0, i[0], 10'h0});
      repeat (3) @(negedge clock);
      chk({31'h0, keyIsYuv}, 32'(i == 0));
    end
    $display("test done: registers");
    wr(OFS_GAMMA_INDEX, 32'hfe);
    for (int i = 0; i < 256; i++) wr(OFS_GAMMA_ENTRY, {gam(8'(i + 254)), 8'(rnd())});
    rdc(OFS_GAMMA_INDEX, 32'hfe);
    wr(OFS_GAMMA_INDEX, 32'hff);
    rdc(OFS_GAMMA_ENTRY, {gam(8'hff), 8'h0});
    rdc(OFS_GAMMA_ENTRY, {gam(8'h0), 8'h0});
    rdc(OFS_GAMMA_INDEX, 32'h1);
    wr(OFS_OUTPUT_CFG, 32'h9);
    wr(OFS_HWINDOW, 32'h0);
    wr(OFS_MISC, RST_MISC);
    // Host read of the entry register stalls the lookup stage one cycle
    for (int k = 0; k < 6; k++) begin
      wr(OFS_GAMMA_INDEX, 32'h3);
      g = 24'(rnd());
      src = 24'(rnd());
      pix(g, 24'h0, gmap(g));
      @(negedge clock);
      gfxPixel = src;
      regAddr = OFS_GAMMA_ENTRY;
      regRd = 1'b1;
      @(negedge clock);
      regRd = 1'b0;
      chk(regRdata, {gam(8'h3), 8'h0});
      @(negedge clock);
      if (dacBlank === 1'b0) chk({8'h0, crtPixel}, {8'h0, gmap(g)});
      @(negedge clock);
      if (dacBlank === 1'b0) chk({8'h0, crtPixel}, {8'h0, gmap(src)});
    end
    for (int b = 0; b < 2; b++) begin
      wr(OFS_MISC, RST_MISC | 32'(b));
      for (int i = 0; i < 12; i++) begin
        g = 24'(rnd());
        e = b ? g : gmap(g);
        pix(g, 24'(rnd()), e);
      end
    end
    $display("test done: gamma");
    wr(OFS_HWINDOW, 32'h0fff_0000);
    wr(OFS_VWINDOW, 32'h07ff_0000);
    wr(OFS_MISC, RST_MISC | 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_OUTPUT_CFG, 32'h9 | (32'(s) << B_KEY_SRC));
      key = rnd();
      msk = rnd();
      wr(OFS_KEY, key);
      wr(OFS_MASK, msk);
      for (int i = 0; i < 20; i++) begin
        g = 24'(rnd());
        v = 24'(rnd());
        fix = key[23:0] ^ (24'(rnd()) & ~msk[23:0]);
        if (i[0]) begin
          if (s == 1) v = fix;
          else g = fix;
        end
        src = s ? v : g;
        hit = ((src ^ key[23:0]) & msk[23:0]) == 24'h0;
        e = (s ? !hit : hit) ? v : g;
        pix(g, v, e);
      end
    end
    $display("test done: key");
    for (int p = 0; p < 2; p++) begin
      wr(OFS_OUTPUT_CFG, p ? 32'h89 : 32'hc9);
      n = 0;
      while (panelPowerOn !== 1'(!p) && n < 400) begin
        @(negedge clock);
        n++;
      end
      chk({31'h0, panelPowerOn}, 32'(!p));
      rdc(OFS_OUTPUT_CFG, p ? 32'h89 : 32'h0800_00c9);
    end
    for (int s = 0; s < 2; s++) begin
      wr(OFS_OUTPUT_CFG, s ? 32'h7 : 32'h105);
      // The idle level flips with the polarity bit; let that edge pass first
      repeat (4) @(negedge clock);
      n = syncEdges;
      repeat (200) @(negedge clock);
      chk(32'(syncEdges != n), 32'(s));
    end
    $display("test done: panel and sync");
    wr(OFS_MISC, 32'h1000);
    for (int dv = 0; dv < 4; dv++) begin
      wr(OFS_PLL, 32'(dv) << F_PLL_DIV_LO);
      repeat (16) @(negedge clock);
      n = 0;
      repeat (64) begin
        @(negedge clock);
        n += int'(secondPllTick);
      end
      chk(32'(n), 32'(64 >> dv));
    end
    $display("test done: divider");
    give_verdict();
  end
endmodule : tb_top

// ===== vodc_display_model.sv
`timescale 1ns/10ps
// ==========================================
// Raster source and monitor
module vodc_display_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic crtHsync,
  output logic lineSyncIn,
  output logic frameSyncIn,
  output logic lineBlankIn,
  output logic frameBlankIn,
  output logic [11:0] pixelX,
  output logic [10:0] lineY,
  output int syncEdges
);
  // Tiny 16x8 raster keeps frame edges frequent
  logic prevSync;
  always @(negedge clock or negedge resetn) begin
    if (!resetn) begin
      pixelX <= 12'h0;
      lineY <= 11'h0;
    end else begin
      pixelX <= pixelX == 12'hf ? 12'h0 : pixelX + 12'h1;
      if (pixelX == 12'hf) lineY <= lineY == 11'h7 ? 11'h0 : lineY + 11'h1;
    end
  end
  assign lineSyncIn = pixelX < 12'h2;
  assign lineBlankIn = pixelX > 12'hb;
  assign frameSyncIn = lineY == 11'h0;
  assign frameBlankIn = lineY > 11'h5;
  always @(posedge clock) begin
    prevSync <= crtHsync;
    if (!resetn) syncEdges <= 0;
    else if (prevSync !== crtHsync) syncEdges <= syncEdges + 1;
  end
endmodule : vodc_display_model

// ===== vodc_pkg.sv
// What this block does
// - Line sync polarity bit 8 inverts idle level
// - Panel gate bit 7 zeroes panel data while the panel is not on
// - Power request level starts power-up; a falling edge starts power-down
// - Blanking bit 3 clear blanks DACs always
// - Bits 2/1 clear suppress frame/line sync outputs
// - Bit 0 clear holds monitor logic reset
// - Right edge bits 27:16, exclusive, minus 13; the window compare uses pixelX as is, with no offset
// - Left edge bits 11:0, minus 14 offset; the window compare uses pixelX as is, with no offset
// - Top edge bits 10:0; bottom exclusive
// - Vertical step bits 29:16, 2000h unity
// - Horizontal step bits 13:0, over 8192
// - Select 0: video where masked graphics matches
// - Select 1: video where mismatching; YUV flag
// - Zero mask bits are ignored in compare
// - Entry: blue 31:24, green 23:16, red 15:8
// - Host gamma access holds output one cycle
// - Gamma enable bit 0 low routes through RAM
// - Bits 12/11/10 control PLL, analog, DAC sleep
// - Bits 22:21 divide second PLL by 1/2/4/8
// - RGB input select: 0 YUV, 1 RGB
package vodc_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_OUTPUT_CFG = 8'h04;
  localparam logic [7:0] OFS_HWINDOW = 8'h08;
  localparam logic [7:0] OFS_VWINDOW = 8'h0c;
  localparam logic [7:0] OFS_SCALE = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_GAMMA_INDEX = 8'h1c;
  localparam logic [7:0] OFS_GAMMA_ENTRY = 8'h20;
  localparam logic [7:0] OFS_MISC = 8'h28;
  localparam logic [7:0] OFS_PLL = 8'h2c;
  localparam logic [7:0] OFS_FORMAT = 8'h4c;
  // ==========================================
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_MISC = 32'h0000_1400;
  // ==========================================
  // Output configuration fields
  localparam int B_RUN = 0;
  localparam int B_HSYNC_EN = 1;
  localparam int B_VSYNC_EN = 2;
  localparam int B_BLANK_NORMAL = 3;
  localparam int B_PANEL_POWER = 6;
  localparam int B_PANEL_GATE = 7;
  localparam int B_HSYNC_POL = 8;
  localparam int B_VSYNC_POL = 9;
  localparam int F_SEQ_DLY_LO = 17;
  localparam int B_KEY_SRC = 20;
  localparam int B_GAMMA_SRC = 21;
  localparam int B_PANEL_ON = 27;
  localparam logic [31:0] OUTPUT_CFG_WMASK = 32'h003e_03cf;
  // ==========================================
  // Window, scale, key fields
  localparam int F_HI_LO = 16;
  localparam int SCALE_FRAC_BITS = 13;
  localparam logic [13:0] SCALE_UNITY = 14'h2000;
  localparam logic [31:0] HWIN_WMASK = 32'h0fff_0fff;
  localparam logic [31:0] VWIN_WMASK = 32'h07ff_07ff;
  localparam logic [31:0] SCALE_WMASK = 32'h3fff_3fff;
  localparam logic [31:0] KEY_WMASK = 32'h00ff_ffff;
  // ==========================================
  // Misc, PLL and format fields
  localparam int B_GAMMA_BYPASS = 0;
  localparam int B_DAC_SLEEP = 10;
  localparam int B_ANALOG_SLEEP = 11;
  localparam int B_PLL_RUN = 12;
  localparam logic [31:0] MISC_WMASK = 32'h0000_1c01;
  localparam int F_PLL_DIV_LO = 21;
  localparam logic [31:0] PLL_WMASK = 32'h0060_0000;
  localparam int B_VIDEO_CONVERT = 10;
  localparam int B_RGB_INPUT = 13;
  localparam logic [31:0] FORMAT_WMASK = 32'h0000_2400;
  localparam int GAMMA_DEPTH = 256;

  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } vodc_pixel_t;

  typedef enum logic [1:0] {
    PNL_OFF = 2'b00,
    PNL_UP = 2'b01,
    PNL_ON = 2'b11,
    PNL_DOWN = 2'b10
  } vodc_panel_t;
endpackage : vodc_pkg

// ===== vodc_properties.sv
`timescale 1ns/10ps
// ==========================================
// Display control checker
module vodc_properties
  import vodc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic [31:0] regWdata,
  input wire logic lineSyncIn,
  input wire logic lineBlankIn,
  input wire logic frameBlankIn,
  input wire logic crtHsync,
  input wire logic crtVsync,
  input wire logic dacBlank,
  input wire vodc_pixel_t crtPixel,
  input wire vodc_pixel_t panelPixel,
  input wire logic panelPowerOn,
  input wire logic monitorLogicResetN,
  input wire logic [13:0] horizontalScaleStep,
  input wire logic [13:0] verticalScaleStep,
  input wire logic secondPllRun,
  input wire logic bandgapRun,
  input wire logic converterSleep,
  input wire logic secondPllTick
);
  // Shadows of written registers; checks wait for quiet so pipeline latency is moot
  logic [31:0] cfg_r, misc_r, scale_r, pll_r;
  logic [3:0] q_r, gap_r;
  logic blankAny, quiet;
  assign blankAny = lineBlankIn | frameBlankIn;
  assign quiet = q_r >= 4'h3;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= RST_ZERO;
      misc_r <= RST_MISC;
      scale_r <= RST_ZERO;
      pll_r <= RST_ZERO;
      q_r <= 4'h0;
      gap_r <= 4'h0;
    end else begin
      q_r <= regWr ? 4'h0 : (q_r == 4'hf ? q_r : q_r + 4'h1);
      gap_r <= secondPllTick ? 4'h0 : (gap_r == 4'hf ? gap_r : gap_r + 4'h1);
      if (regWr && regAddr == OFS_OUTPUT_CFG) cfg_r <= regWdata & OUTPUT_CFG_WMASK;
      if (regWr && regAddr == OFS_MISC) misc_r <= regWdata & MISC_WMASK;
      if (regWr && regAddr == OFS_SCALE) scale_r <= regWdata & SCALE_WMASK;
      if (regWr && regAddr == OFS_PLL) pll_r <= regWdata & PLL_WMASK;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Properties
  property p_line_sync;
    quiet && cfg_r[B_RUN] && cfg_r[B_HSYNC_EN] |-> crtHsync == ($past(lineSyncIn, 2) ^ cfg_r[B_HSYNC_POL]);
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("line sync level wrong");
  property p_sync_gate;
    quiet |-> (cfg_r[B_RUN] && cfg_r[B_HSYNC_EN] || crtHsync == cfg_r[B_HSYNC_POL])
      && (cfg_r[B_RUN] && cfg_r[B_VSYNC_EN] || crtVsync == cfg_r[B_VSYNC_POL]);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync not idle");
  property p_dac_off;
    quiet && !cfg_r[B_BLANK_NORMAL] |-> dacBlank && crtPixel == '0;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("dac not blanked");
  property p_dac_normal;
    quiet && cfg_r[B_BLANK_NORMAL] && cfg_r[B_RUN] |-> dacBlank == $past(blankAny, 2);
  endproperty
  a_dac_normal: assert property (p_dac_normal) else $error("blank timing wrong");
  property p_run;
    quiet |-> monitorLogicResetN == cfg_r[B_RUN];
  endproperty
  a_run: assert property (p_run) else $error("monitor reset wrong");
  property p_panel_gate;
    quiet && cfg_r[B_PANEL_GATE] && !panelPowerOn && !$past(panelPowerOn, 2) |-> panelPixel == '0;
  endproperty
  a_panel_gate: assert property (p_panel_gate) else $error("panel data leaked");
  property p_panel_pass;
    quiet && !cfg_r[B_PANEL_GATE] |-> panelPixel == crtPixel;
  endproperty
  a_panel_pass: assert property (p_panel_pass) else $error("panel data differs");
  property p_sleep;
    quiet |-> converterSleep == misc_r[B_DAC_SLEEP] && bandgapRun == !misc_r[B_ANALOG_SLEEP]
      && secondPllRun == (misc_r[B_PLL_RUN] && !misc_r[B_ANALOG_SLEEP]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("power down wrong");
  property p_scale;
    quiet |-> horizontalScaleStep == scale_r[13:0] && verticalScaleStep == scale_r[29:16];
  endproperty
  a_scale: assert property (p_scale) else $error("scale step wrong");
  property p_tick;
    q_r >= 4'hc && secondPllRun && secondPllTick |-> gap_r == (4'h1 << pll_r[22:21]) - 4'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("divider period wrong");
  c_panel_on: cover property ($rose(panelPowerOn));
  c_tick8: cover property (secondPllTick && pll_r[22:21] == 2'b11);
  c_video: cover property (quiet && cfg_r[B_KEY_SRC] && !dacBlank);
endmodule : vodc_properties
bind vodc_top vodc_properties chk_u (.clock, .resetn, .regAddr, .regWr, .regWdata, .lineSyncIn,
  .lineBlankIn, .frameBlankIn, .crtHsync, .crtVsync, .dacBlank, .crtPixel, .panelPixel, .panelPowerOn,
  .monitorLogicResetN, .horizontalScaleStep, .verticalScaleStep, .secondPllRun, .bandgapRun,
  .converterSleep, .secondPllTick);

// ===== vodc_top.sv
`timescale 1ns/10ps
module vodc_top
  import vodc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  input wire logic lineSyncIn,
  input wire logic frameSyncIn,
  input wire logic lineBlankIn,
  input wire logic frameBlankIn,
  input wire logic [11:0] pixelX,
  input wire logic [10:0] lineY,
  input wire vodc_pixel_t gfxPixel,
  input wire vodc_pixel_t vidPixel,
  output logic crtHsync,
  output logic crtVsync,
  output logic dacBlank,
  output vodc_pixel_t crtPixel,
  output vodc_pixel_t panelPixel,
  output logic panelPowerOn,
  output logic monitorLogicResetN,
  output logic keyIsYuv,
  output logic [13:0] horizontalScaleStep,
  output logic [13:0] verticalScaleStep,
  output logic secondPllRun,
  output logic bandgapRun,
  output logic converterSleep,
  output logic secondPllTick
);
  // ==========================================
  // Register file
  logic [31:0] outCfg_r, outCfg_nxt;
  logic [31:0] hWin_r, hWin_nxt;
  logic [31:0] vWin_r, vWin_nxt;
  logic [31:0] scale_r, scale_nxt;
  logic [31:0] key_r, key_nxt;
  logic [31:0] mask_r, mask_nxt;
  logic [7:0] gIndex_r, gIndex_nxt;
  logic [31:0] misc_r, misc_nxt;
  logic [31:0] pll_r, pll_nxt;
  logic [31:0] fmt_r, fmt_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic hostGamma;
  logic panelIsOn;
  vodc_pixel_t gammaRam [GAMMA_DEPTH];
  vodc_pixel_t entryRd;

  assign entryRd = gammaRam[gIndex_r];
  assign hostGamma = (regWr | regRd) && regAddr == OFS_GAMMA_ENTRY;

  always_comb begin
    outCfg_nxt = outCfg_r;
    hWin_nxt = hWin_r;
    vWin_nxt = vWin_r;
    scale_nxt = scale_r;
    key_nxt = key_r;
    mask_nxt = mask_r;
    gIndex_nxt = gIndex_r;
    misc_nxt = misc_r;
    pll_nxt = pll_r;
    fmt_nxt = fmt_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = regRd;
    if (hostGamma) begin
      gIndex_nxt = gIndex_r + 8'h01;
    end
    if (regWr) begin
      unique case (regAddr)
        OFS_OUTPUT_CFG: outCfg_nxt = regWdata & OUTPUT_CFG_WMASK;
        OFS_HWINDOW: hWin_nxt = regWdata & HWIN_WMASK;
        OFS_VWINDOW: vWin_nxt = regWdata & VWIN_WMASK;
        OFS_SCALE: scale_nxt = regWdata & SCALE_WMASK;
        OFS_KEY: key_nxt = regWdata & KEY_WMASK;
        OFS_MASK: mask_nxt = regWdata & KEY_WMASK;
        OFS_GAMMA_INDEX: gIndex_nxt = regWdata[7:0];
        OFS_MISC: misc_nxt = regWdata & MISC_WMASK;
        OFS_PLL: pll_nxt = regWdata & PLL_WMASK;
        OFS_FORMAT: fmt_nxt = regWdata & FORMAT_WMASK;
        default: ;
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        OFS_OUTPUT_CFG: begin
          rdata_nxt = outCfg_r;
          rdata_nxt[B_PANEL_ON] = panelIsOn;
        end
        OFS_HWINDOW: rdata_nxt = hWin_r;
        OFS_VWINDOW: rdata_nxt = vWin_r;
        OFS_SCALE: rdata_nxt = scale_r;
        OFS_KEY: rdata_nxt = key_r;
        OFS_MASK: rdata_nxt = mask_r;
        OFS_GAMMA_INDEX: rdata_nxt = {24'h000000, gIndex_r};
        OFS_GAMMA_ENTRY: rdata_nxt = {entryRd, 8'h00};
        OFS_MISC: rdata_nxt = misc_r;
        OFS_PLL: rdata_nxt = pll_r;
        OFS_FORMAT: rdata_nxt = fmt_r;
        default: rdata_nxt = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outCfg_r <= RST_ZERO;
      hWin_r <= RST_ZERO;
      vWin_r <= RST_ZERO;
      scale_r <= RST_ZERO;
      key_r <= RST_ZERO;
      mask_r <= RST_ZERO;
      gIndex_r <= 8'h00;
      misc_r <= RST_MISC;
      pll_r <= RST_ZERO;
      fmt_r <= RST_ZERO;
      rdata_r <= RST_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      outCfg_r <= outCfg_nxt;
      hWin_r <= hWin_nxt;
      vWin_r <= vWin_nxt;
      scale_r <= scale_nxt;
      key_r <= key_nxt;
      mask_r <= mask_nxt;
      gIndex_r <= gIndex_nxt;
      misc_r <= misc_nxt;
      pll_r <= pll_nxt;
      fmt_r <= fmt_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // RAM has no reset; contents are undefined until software loads them
  always_ff @(posedge clock) begin
    if (regWr && regAddr == OFS_GAMMA_ENTRY) begin
      gammaRam[gIndex_r] <= regWdata[31:8];
    end
  end

  // ==========================================
  // Panel power sequencer
  vodc_panel_t panel_r, panel_nxt;
  logic powerReq_r, powerReq_nxt;
  logic frameSyncPrev_r, frameSyncPrev_nxt;
  logic [3:0] frameCnt_r, frameCnt_nxt;
  logic [3:0] seqFrames;
  logic frameTick;

  assign seqFrames = {1'b0, outCfg_r[F_SEQ_DLY_LO +: 3]} + 4'h1;
  assign frameTick = frameSyncIn & ~frameSyncPrev_r;

  always_comb begin
    panel_nxt = panel_r;
    powerReq_nxt = outCfg_r[B_PANEL_POWER];
    frameSyncPrev_nxt = frameSyncIn;
    frameCnt_nxt = frameCnt_r;
    if (frameTick) begin
      frameCnt_nxt = frameCnt_r + 4'h1;
    end
    unique case (panel_r)
      PNL_OFF: begin
        // Level test, so a rise during power-down is not lost
        if (outCfg_r[B_PANEL_POWER]) begin
          panel_nxt = PNL_UP;
          frameCnt_nxt = 4'h0;
        end
      end
      PNL_UP: begin
        if (!outCfg_r[B_PANEL_POWER]) begin
          panel_nxt = PNL_DOWN;
          frameCnt_nxt = 4'h0;
        end else if (frameCnt_r >= seqFrames) begin
          panel_nxt = PNL_ON;
        end
      end
      PNL_ON: begin
        if (!outCfg_r[B_PANEL_POWER] && powerReq_r) begin
          panel_nxt = PNL_DOWN;
          frameCnt_nxt = 4'h0;
        end
      end
      PNL_DOWN: begin
        if (frameCnt_r >= seqFrames) begin
          panel_nxt = PNL_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      panel_r <= PNL_OFF;
      powerReq_r <= 1'b0;
      frameSyncPrev_r <= 1'b0;
      frameCnt_r <= 4'h0;
    end else begin
      panel_r <= panel_nxt;
      powerReq_r <= powerReq_nxt;
      frameSyncPrev_r <= frameSyncPrev_nxt;
      frameCnt_r <= frameCnt_nxt;
    end
  end

  assign panelIsOn = panel_r == PNL_ON;

  // ==========================================
  // Pixel path, stage 1: window, key, gamma
  logic inWin1_r, inWin1_nxt;
  logic keyHit1_r, keyHit1_nxt;
  logic blank1_r, blank1_nxt;
  logic hs1_r, hs1_nxt;
  logic vs1_r, vs1_nxt;
  vodc_pixel_t gfx1_r, gfx1_nxt;
  vodc_pixel_t vid1_r, vid1_nxt;
  vodc_pixel_t gamma1_r, gamma1_nxt;
  vodc_pixel_t gammaIn;
  logic [23:0] keyStream;

  always_comb begin
    // Exclusive right and bottom edges
    inWin1_nxt = pixelX >= hWin_r[11:0] && pixelX < hWin_r[F_HI_LO +: 12]
      && lineY >= vWin_r[10:0] && lineY < vWin_r[F_HI_LO +: 11];
    keyStream = outCfg_r[B_KEY_SRC] ? vidPixel : gfxPixel;
    keyHit1_nxt = ((keyStream ^ key_r[23:0]) & mask_r[23:0]) == 24'h000000;
    blank1_nxt = !outCfg_r[B_BLANK_NORMAL] || lineBlankIn || frameBlankIn;
    hs1_nxt = lineSyncIn;
    vs1_nxt = frameSyncIn;
    gfx1_nxt = gfxPixel;
    vid1_nxt = vidPixel;
    gammaIn = outCfg_r[B_GAMMA_SRC] ? vidPixel : gfxPixel;
    gamma1_nxt.blue = gammaRam[gammaIn.blue].blue;
    gamma1_nxt.green = gammaRam[gammaIn.green].green;
    gamma1_nxt.red = gammaRam[gammaIn.red].red;
    // RAM port is borrowed by the host, so the last lookup is repeated
    if (hostGamma) begin
      gamma1_nxt = gamma1_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inWin1_r <= 1'b0;
      keyHit1_r <= 1'b0;
      blank1_r <= 1'b1;
      hs1_r <= 1'b0;
      vs1_r <= 1'b0;
      gfx1_r <= '0;
      vid1_r <= '0;
      gamma1_r <= '0;
    end else begin
      inWin1_r <= inWin1_nxt;
      keyHit1_r <= keyHit1_nxt;
      blank1_r <= blank1_nxt;
      hs1_r <= hs1_nxt;
      vs1_r <= vs1_nxt;
      gfx1_r <= gfx1_nxt;
      vid1_r <= vid1_nxt;
      gamma1_r <= gamma1_nxt;
    end
  end

  // ==========================================
  // Pixel path, stage 2: mix, syncs, outputs
  logic hs_r, hs_nxt;
  logic vs_r, vs_nxt;
  logic blank_r, blank_nxt;
  logic run_r, run_nxt;
  logic panelOn_r, panelOn_nxt;
  logic yuv_r, yuv_nxt;
  vodc_pixel_t crt_r, crt_nxt;
  vodc_pixel_t panel2_r, panel2_nxt;
  vodc_pixel_t gfxSel, vidSel;
  logic showVideo, run, bypass;

  always_comb begin
    run = outCfg_r[B_RUN];
    bypass = misc_r[B_GAMMA_BYPASS];
    gfxSel = (!bypass && !outCfg_r[B_GAMMA_SRC]) ? gamma1_r : gfx1_r;
    vidSel = (!bypass && outCfg_r[B_GAMMA_SRC]) ? gamma1_r : vid1_r;
    if (outCfg_r[B_KEY_SRC]) begin
      showVideo = inWin1_r && !keyHit1_r;
    end else begin
      showVideo = inWin1_r && keyHit1_r;
    end
    run_nxt = run;
    // Held in reset: syncs at idle level, DACs blanked
    hs_nxt = outCfg_r[B_HSYNC_POL] ^ (hs1_r && run && outCfg_r[B_HSYNC_EN]);
    vs_nxt = outCfg_r[B_VSYNC_POL] ^ (vs1_r && run && outCfg_r[B_VSYNC_EN]);
    blank_nxt = blank1_r || !run;
    crt_nxt = blank_nxt ? '0 : (showVideo ? vidSel : gfxSel);
    panel2_nxt = crt_nxt;
    if (outCfg_r[B_PANEL_GATE] && !panelIsOn) begin
      panel2_nxt = '0;
    end
    panelOn_nxt = panelIsOn;
    yuv_nxt = !fmt_r[B_VIDEO_CONVERT] && !fmt_r[B_RGB_INPUT];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hs_r <= 1'b0;
      vs_r <= 1'b0;
      blank_r <= 1'b1;
      run_r <= 1'b0;
      panelOn_r <= 1'b0;
      yuv_r <= 1'b1;
      crt_r <= '0;
      panel2_r <= '0;
    end else begin
      hs_r <= hs_nxt;
      vs_r <= vs_nxt;
      blank_r <= blank_nxt;
      run_r <= run_nxt;
      panelOn_r <= panelOn_nxt;
      yuv_r <= yuv_nxt;
      crt_r <= crt_nxt;
      panel2_r <= panel2_nxt;
    end
  end

  // ==========================================
  // Analog controls and second PLL divider
  logic [13:0] hStep_r, vStep_r;
  logic pllRun_r, bandgap_r, dacSleep_r, tick_r, tick_nxt;
  logic [2:0] divCnt_r, divCnt_nxt;
  logic [2:0] divLast;

  always_comb begin
    unique case (pll_r[F_PLL_DIV_LO +: 2])
      2'b00: divLast = 3'h0;
      2'b01: divLast = 3'h1;
      2'b10: divLast = 3'h3;
      2'b11: divLast = 3'h7;
    endcase
    divCnt_nxt = (divCnt_r >= divLast) ? 3'h0 : divCnt_r + 3'h1;
    tick_nxt = pllRun_r && divCnt_r >= divLast;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hStep_r <= 14'h0000;
      vStep_r <= 14'h0000;
      pllRun_r <= 1'b0;
      bandgap_r <= 1'b0;
      dacSleep_r <= 1'b1;
      divCnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      hStep_r <= scale_r[13:0];
      vStep_r <= scale_r[F_HI_LO +: 14];
      pllRun_r <= misc_r[B_PLL_RUN] && !misc_r[B_ANALOG_SLEEP];
      bandgap_r <= !misc_r[B_ANALOG_SLEEP];
      dacSleep_r <= misc_r[B_DAC_SLEEP];
      divCnt_r <= divCnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign regRvalid = rvalid_r;
  assign crtHsync = hs_r;
  assign crtVsync = vs_r;
  assign dacBlank = blank_r;
  assign crtPixel = crt_r;
  assign panelPixel = panel2_r;
  assign panelPowerOn = panelOn_r;
  assign monitorLogicResetN = run_r;
  assign keyIsYuv = yuv_r;
  assign horizontalScaleStep = hStep_r;
  assign verticalScaleStep = vStep_r;
  assign secondPllRun = pllRun_r;
  assign bandgapRun = bandgap_r;
  assign converterSleep = dacSleep_r;
  assign secondPllTick = tick_r;
endmodule : vodc_top
